//--- logic/usc_pkg.sv
// shared constants and carrier types of the uart shadow control register block
package usc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] USC_ADDR_TX_LEVEL = 32'h5000_1180;
  localparam logic [31:0] USC_ADDR_RX_LEVEL = 32'h5000_1184;
  localparam logic [31:0] USC_ADDR_SOFT_RST = 32'h5000_1188;
  localparam logic [31:0] USC_ADDR_RTS_SHADOW = 32'h5000_118c;
  localparam logic [31:0] USC_ADDR_BRK_SHADOW = 32'h5000_1190;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int USC_SRR_TX_CLR_BIT = 2;
  localparam int USC_SRR_RX_CLR_BIT = 1;
  localparam int USC_SRR_CTRL_RST_BIT = 0;
  localparam int USC_RTS_ALIAS_BIT = 0;
  localparam int USC_BRK_ALIAS_BIT = 0;
  localparam int USC_LEVEL_W = 16;
  localparam logic [15:0] USC_LEVEL_RST = 16'h0000;
  localparam logic USC_RTS_RST = 1'b0;
  localparam logic USC_BRK_RST = 1'b0;
  localparam logic [31:0] USC_RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // receive trigger codes
  // ----------------------------------------------------------------
  localparam logic [1:0] USC_TRIG_ONE_CHAR = 2'h0;
  localparam logic [1:0] USC_TRIG_QUARTER = 2'h1;
  localparam logic [1:0] USC_TRIG_HALF = 2'h2;
  localparam logic [1:0] USC_TRIG_TWO_LESS = 2'h3;

  // ----------------------------------------------------------------
  // bus encodings, sizes, timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] USC_HTRANS_NONSEQ = 2'h2;
  localparam logic USC_HRESP_OKAY = 1'b0;
  localparam int USC_FIFO_DEPTH = 8;
  localparam int USC_DATA_W = 8;
  localparam int USC_SIR_PERIOD_CYC = 16;
  localparam int USC_SIR_LOW_CYC = 3;

  // configuration bits coming from the main controller registers
  typedef struct packed {
    logic afc_en;
    logic fifo_en;
    logic loopback;
    logic sir_mode;
    logic [1:0] rx_trig;
  } usc_cfg_t;

  // one beat of a character stream
  typedef struct packed {
    logic valid;
    logic [USC_DATA_W-1:0] data;
  } usc_beat_t;

endpackage

//--- logic/usc_rst_sync.sv
// reset synchroniser: asynchronous assertion, release on the clock
`timescale 1ns/1ps
module usc_rst_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n_out
);

  logic stage1_r;
  logic stage1_nxt;
  logic rst_n_nxt;

  always_comb begin
    stage1_nxt = 1'b1;
    rst_n_nxt = stage1_r;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      stage1_r <= stage1_nxt;
      rst_n_out <= rst_n_nxt;
    end
  end

endmodule

//--- logic/usc_fifo.sv
// character fifo with registered flags, level count and synchronous clear
`timescale 1ns/1ps
module usc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [LW-1:0] level_nxt;
  logic in_ready_nxt, out_valid_nxt;
  logic [WIDTH-1:0] out_data_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
    rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
    level_nxt = level + LW'(push) - LW'(pop);
    if (clear) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      level_nxt = '0;
    end
    in_ready_nxt = (level_nxt != LW'(DEPTH));
    out_valid_nxt = (level_nxt != '0);
    // forward a word that lands on the new head in the same cycle
    if (push && !clear && wr_ptr_r == rd_ptr_nxt) begin
      out_data_nxt = in_data;
    end else begin
      out_data_nxt = mem_r[rd_ptr_nxt];
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      level <= level_nxt;
      in_ready <= in_ready_nxt;
      out_valid <= out_valid_nxt;
      out_data <= out_data_nxt;
    end
  end

endmodule

//--- logic/usc_shadow_ctrl.sv
// uart shadow control registers: fifo levels, soft resets, rts and break aliases
//
// Notes on behaviour
// - transmit fifo entry count readable as 16-bit read-only field, zero after reset
// - receive fifo entry count readable as 16-bit read-only field, zero after reset
// - writing one to bit 2 empties the transmit fifo, like the queue control bit
// - writing one to bit 1 empties the receive fifo, like the queue control bit
// - both fifo reset bits clear themselves after acting
// - writing bit 0 resets the controller at once, released on the clock
// - controller reset reaches bus-clock and serial-clock domain logic alike
// - rts alias bit shares storage with the modem control register rts bit
// - without auto flow control or loopback, rts_n is low whenever the rts bit is one
// - auto flow and fifos on: rts_n forced high while rx fill exceeds trigger
// - loopback holds rts_n high and loops the rts bit to the modem input
// - break alias shares line control break storage and forces output to spacing
// - outside loopback the serial output stays low until break is cleared
// - infrared mode with break drives the infrared output with continuous pulses
// - in loopback the break is fed back to the own receiver, not to sout; infrared break pulses still reach sir_out_n
// - two-bit trigger code: one char, quarter, half, two less than full
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module usc_shadow_ctrl
  import usc_pkg::*;
#(
  parameter int DATA_W = USC_DATA_W,
  parameter int FIFO_DEPTH = USC_FIFO_DEPTH,
  parameter int SIR_PERIOD_CYC = USC_SIR_PERIOD_CYC,
  parameter int SIR_LOW_CYC = USC_SIR_LOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // main controller register side
  input wire usc_cfg_t cfg,
  input wire logic mcr_rts_we,
  input wire logic mcr_rts_wdata,
  input wire logic lcr_brk_we,
  input wire logic lcr_brk_wdata,
  input wire logic fcr_tx_clear,
  input wire logic fcr_rx_clear,
  output logic rts_bit,
  output logic break_bit,
  // character streams through the fifos
  input wire usc_beat_t tx_in,
  output logic tx_in_ready,
  output logic tx_out_valid,
  output logic [DATA_W-1:0] tx_out_data,
  input wire logic tx_out_ready,
  input wire usc_beat_t rx_in,
  output logic rx_in_ready,
  output logic rx_out_valid,
  output logic [DATA_W-1:0] rx_out_data,
  input wire logic rx_out_ready,
  // serial side
  input wire logic tx_serial,
  input wire logic sir_tx_n,
  output logic sout,
  output logic sir_out_n,
  output logic rts_n,
  output logic loop_rts,
  output logic loop_sin,
  output logic ctrl_rst_n
);

  localparam int LW = $clog2(FIFO_DEPTH+1);
  localparam int SW = $clog2(SIR_PERIOD_CYC+1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [USC_LEVEL_W-1:0] trig_level(input logic [1:0] code);
    case (code)
      USC_TRIG_ONE_CHAR: trig_level = USC_LEVEL_W'(1);
      USC_TRIG_QUARTER: trig_level = USC_LEVEL_W'(FIFO_DEPTH / 4);
      USC_TRIG_HALF: trig_level = USC_LEVEL_W'(FIFO_DEPTH / 2);
      default: trig_level = USC_LEVEL_W'(FIFO_DEPTH - 2);
    endcase
  endfunction

  function automatic logic [USC_LEVEL_W-1:0] widen_level(input logic [LW-1:0] lvl);
    widen_level = USC_LEVEL_W'(lvl);
  endfunction

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic wr_pend_r, wr_pend_nxt;
  logic [31:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic tx_clr_r, tx_clr_nxt;
  logic rx_clr_r, rx_clr_nxt;
  logic soft_req_r, soft_req_nxt;
  logic addr_phase;
  logic wr_srr, wr_rts, wr_brk;
  logic rts_rd, brk_rd;

  // ----------------------------------------------------------------
  // controller state (on the controller reset)
  // ----------------------------------------------------------------
  logic rts_nxt, brk_nxt;
  logic rts_n_nxt, sout_nxt, sir_out_n_nxt, loop_rts_nxt, loop_sin_nxt;
  logic [SW-1:0] sir_cnt_r, sir_cnt_nxt;
  logic [LW-1:0] tx_level, rx_level;
  logic rx_above;
  logic sync_arst_n;

  // ----------------------------------------------------------------
  // controller reset
  // ----------------------------------------------------------------
  // the request flop is itself on hresetn, so the bus keeps answering
  // while the rest of the controller sits in reset
  assign sync_arst_n = hresetn & ~soft_req_r;

  // ctrl_rst_n is also handed to the serial-clock side of the controller
  usc_rst_sync u_rst_sync (
    .clk(hclk),
    .arst_n(sync_arst_n),
    .rst_n_out(ctrl_rst_n)
  );

  // ----------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------
  usc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(hclk),
    .rst_n(ctrl_rst_n),
    .clear(tx_clr_r | fcr_tx_clear),
    .in_valid(tx_in.valid),
    .in_data(tx_in.data),
    .in_ready(tx_in_ready),
    .out_valid(tx_out_valid),
    .out_data(tx_out_data),
    .out_ready(tx_out_ready),
    .level(tx_level)
  );

  usc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(hclk),
    .rst_n(ctrl_rst_n),
    .clear(rx_clr_r | fcr_rx_clear),
    .in_valid(rx_in.valid),
    .in_data(rx_in.data),
    .in_ready(rx_in_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data),
    .out_ready(rx_out_ready),
    .level(rx_level)
  );

  // ----------------------------------------------------------------
  // bus decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    // nonseq and seq start a transfer; idle and busy must not
    addr_phase = hsel & hready & htrans[1];
    wr_srr = wr_pend_r & (wr_addr_r == USC_ADDR_SOFT_RST);
    wr_rts = wr_pend_r & (wr_addr_r == USC_ADDR_RTS_SHADOW);
    wr_brk = wr_pend_r & (wr_addr_r == USC_ADDR_BRK_SHADOW);
    // a read right behind a write sees the value being written
    rts_rd = wr_rts ? hwdata[USC_RTS_ALIAS_BIT] : rts_bit;
    brk_rd = wr_brk ? hwdata[USC_BRK_ALIAS_BIT] : break_bit;
    wr_pend_nxt = addr_phase & hwrite;
    wr_addr_nxt = addr_phase ? haddr : wr_addr_r;
    hrdata_nxt = USC_RDATA_ZERO;
    if (addr_phase && !hwrite) begin
      case (haddr)
        USC_ADDR_TX_LEVEL: hrdata_nxt = 32'(widen_level(tx_level));
        USC_ADDR_RX_LEVEL: hrdata_nxt = 32'(widen_level(rx_level));
        USC_ADDR_RTS_SHADOW: hrdata_nxt[USC_RTS_ALIAS_BIT] = rts_rd;
        USC_ADDR_BRK_SHADOW: hrdata_nxt[USC_BRK_ALIAS_BIT] = brk_rd;
        default: hrdata_nxt = USC_RDATA_ZERO;
      endcase
    end
    // reset bits act as one-cycle pulses and never hold a value
    tx_clr_nxt = wr_srr & hwdata[USC_SRR_TX_CLR_BIT];
    rx_clr_nxt = wr_srr & hwdata[USC_SRR_RX_CLR_BIT];
    soft_req_nxt = wr_srr & hwdata[USC_SRR_CTRL_RST_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata <= USC_RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp <= USC_HRESP_OKAY;
      tx_clr_r <= 1'b0;
      rx_clr_r <= 1'b0;
      soft_req_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= USC_HRESP_OKAY;
      tx_clr_r <= tx_clr_nxt;
      rx_clr_r <= rx_clr_nxt;
      soft_req_r <= soft_req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // rts and break storage, line outputs
  // ----------------------------------------------------------------
  always_comb begin
    // bus alias and main register write one bit; the bus wins a tie
    rts_nxt = rts_bit;
    if (wr_rts) begin
      rts_nxt = hwdata[USC_RTS_ALIAS_BIT];
    end else if (mcr_rts_we) begin
      rts_nxt = mcr_rts_wdata;
    end
    brk_nxt = break_bit;
    if (wr_brk) begin
      brk_nxt = hwdata[USC_BRK_ALIAS_BIT];
    end else if (lcr_brk_we) begin
      brk_nxt = lcr_brk_wdata;
    end

    rx_above = widen_level(rx_level) > trig_level(cfg.rx_trig);
    if (cfg.loopback) begin
      rts_n_nxt = 1'b1;
    end else if (cfg.afc_en && cfg.fifo_en && rx_above) begin
      rts_n_nxt = 1'b1;
    end else begin
      rts_n_nxt = ~rts_bit;
    end
    loop_rts_nxt = cfg.loopback & rts_bit;

    // in loopback the line idles high and the receiver sees the break
    if (cfg.loopback) begin
      sout_nxt = 1'b1;
      loop_sin_nxt = break_bit ? 1'b0 : tx_serial;
    end else begin
      sout_nxt = break_bit ? 1'b0 : tx_serial;
      loop_sin_nxt = 1'b1;
    end

    // infrared break: free-running low pulses rather than a steady level
    if (cfg.sir_mode && break_bit) begin
      sir_cnt_nxt = (sir_cnt_r == SW'(SIR_PERIOD_CYC - 1)) ? '0 : sir_cnt_r + SW'(1);
      sir_out_n_nxt = ~(sir_cnt_r < SW'(SIR_LOW_CYC));
    end else begin
      sir_cnt_nxt = '0;
      sir_out_n_nxt = sir_tx_n;
    end
  end

  always_ff @(posedge hclk or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      rts_bit <= USC_RTS_RST;
      break_bit <= USC_BRK_RST;
      rts_n <= 1'b1;
      sout <= 1'b1;
      sir_out_n <= 1'b1;
      loop_rts <= 1'b0;
      loop_sin <= 1'b1;
      sir_cnt_r <= '0;
    end else begin
      rts_bit <= rts_nxt;
      break_bit <= brk_nxt;
      rts_n <= rts_n_nxt;
      sout <= sout_nxt;
      sir_out_n <= sir_out_n_nxt;
      loop_rts <= loop_rts_nxt;
      loop_sin <= loop_sin_nxt;
      sir_cnt_r <= sir_cnt_nxt;
    end
  end

endmodule

//--- dv/usc_modem_model.sv
// modem side model: feeds received characters, drains the transmit queue
`timescale 1ns/1ps
module usc_modem_model
  import usc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic drain,
  input wire logic rts_n,
  input wire logic rx_in_ready,
  output usc_beat_t rx_in,
  output logic tx_out_ready
);
  logic [2:0] gap_r;
  logic [7:0] seq_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_in <= '0;
      gap_r <= 3'h0;
      seq_r <= 8'h00;
      tx_out_ready <= 1'b0;
    end else begin
      // half-rate pop, so the queue sees a stalling reader
      tx_out_ready <= drain && !tx_out_ready;
      if (rx_in.valid && rx_in_ready) begin
        rx_in <= '{1'b0, ~rx_in.data};
        gap_r <= 3'h3;
        seq_r <= seq_r + 8'h01;
      end else if (!rx_in.valid) begin
        // gap lets rts_n settle before the next offer
        if (gap_r != 3'h0) begin
          gap_r <= gap_r - 3'h1;
          rx_in.data <= ~rx_in.data;
        end else if (go && !rts_n) begin
          rx_in <= '{1'b1, seq_r};
        end else begin
          // idle byte keeps changing, never mistaken for data
          rx_in.data <= ~rx_in.data;
        end
      end
    end
  end
endmodule

//--- dv/usc_shadow_ctrl_chk.sv
// concurrent checks on the shadow control register block ports
`timescale 1ns/1ps
module usc_shadow_ctrl_chk
  import usc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire usc_cfg_t cfg,
  input wire logic rts_bit,
  input wire logic break_bit,
  input wire logic sout,
  input wire logic rts_n,
  input wire logic loop_rts,
  input wire logic loop_sin,
  input wire logic ctrl_rst_n
);
  logic [2:0] ph_q;
  wire acc = hsel && hready && htrans[1];
  wire srr = haddr == USC_ADDR_SOFT_RST;
  // bits: soft reset write, soft reset access, read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= {acc && hwrite && srr, acc && srr, acc && !hwrite};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_read_zero: assert property (ph_q[0] |-> hrdata[31:16] == 16'h0000 && (!ph_q[1] || hrdata == 32'h0000_0000))
    else $error("reserved or write-only bits read nonzero");
  a_soft_reset: assert property ((ph_q[2] && hwdata[0]) |=> !ctrl_rst_n ##[1:4] ctrl_rst_n)
    else $error("controller reset pulse wrong");
  a_reset_release: assert property ($rose(hresetn) |-> !ctrl_rst_n ##[1:3] ctrl_rst_n)
    else $error("controller reset not released on the clock");
  a_rts_plain: assert property ((ctrl_rst_n && !cfg.loopback && !cfg.afc_en) |=>
    !ctrl_rst_n || rts_n == !$past(rts_bit))
    else $error("rts_n does not follow the rts bit");
  a_loop_rts: assert property ((ctrl_rst_n && cfg.loopback) |=>
    !ctrl_rst_n || (rts_n && loop_rts == $past(rts_bit)))
    else $error("loopback rts handling wrong");
  a_brk_spacing: assert property ((ctrl_rst_n && !cfg.loopback && break_bit) [*2] |-> !sout)
    else $error("line not held at spacing during break");
  a_loop_brk: assert property ((ctrl_rst_n && cfg.loopback && break_bit) |=> !ctrl_rst_n || (sout && !loop_sin))
    else $error("loopback break not fed to receiver");
  c_soft_reset: cover property ($fell(ctrl_rst_n));
  c_loop_brk: cover property (cfg.loopback && break_bit);
  c_afc_hold: cover property (cfg.afc_en && rts_n && rts_bit);
endmodule
bind usc_shadow_ctrl usc_shadow_ctrl_chk u_chk (.*);

//--- dv/tb_usc_shadow_ctrl.sv
// self-checking bench for the shadow control register block
`timescale 1ns/1ps
module tb_usc_shadow_ctrl;
  import usc_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic n;
  } usc_tbrow_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, drain = 0, rx_out_ready = 0;
  logic mcr_rts_we = 0, mcr_rts_wdata = 0, lcr_brk_we = 0, lcr_brk_wdata = 0;
  logic fcr_tx_clear = 0, fcr_rx_clear = 0, tx_serial = 1, sir_tx_n = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  usc_cfg_t cfg = '0;
  usc_beat_t tx_in = '0, rx_in;
  logic hreadyout, hresp, rts_bit, break_bit, tx_in_ready, tx_out_valid, tx_out_ready;
  logic rx_in_ready, rx_out_valid, sout, sir_out_n, rts_n, loop_rts, loop_sin, ctrl_rst_n;
  logic [7:0] tx_out_data, rx_out_data;
  int err_total = 0, checked = 0, n;
  int trg [4] = '{1, USC_FIFO_DEPTH / 4, USC_FIFO_DEPTH / 2, USC_FIFO_DEPTH - 2};
  usc_tbrow_t rows [8] = '{
    '{USC_ADDR_TX_LEVEL, 32'hffff_ffff, 32'h0000_0000, 1'b1},
    '{USC_ADDR_RX_LEVEL, 32'hffff_ffff, 32'h0000_0000, 1'b1},
    '{USC_ADDR_SOFT_RST, 32'h0000_0006, 32'h0000_0000, 1'b1},
    '{USC_ADDR_RTS_SHADOW, 32'hffff_ffff, 32'h0000_0001, 1'b0},
    '{USC_ADDR_BRK_SHADOW, 32'hffff_ffff, 32'h0000_0001, 1'b0},
    '{USC_ADDR_BRK_SHADOW, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{USC_ADDR_RTS_SHADOW, 32'h0000_fffe, 32'h0000_0000, 1'b1},
    '{32'h5000_1194, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
  always #20 hclk = ~hclk;
  usc_shadow_ctrl u_dut (.hready(hreadyout), .*);
  usc_modem_model u_modem (.*);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 100) begin
      @(posedge hclk);
      k++;
    end
    if (s !== v) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= USC_HTRANS_NONSEQ;
    @(posedge hclk);
    wait_for(hreadyout, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // read data stands the whole data phase; take it where it is settled
    @(negedge hclk);
    rd = hrdata;
    @(posedge hclk);
    wait_for(hreadyout, 1'b1);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, ex, rd);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    step(10);
    hresetn <= 1'b1;
    step(3);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rdc("row read", rows[i].a, rows[i].e);
      chk("row rts_n", 32'(rts_n), 32'(rows[i].n));
    end
    mcr_rts_we <= 1'b1;
    mcr_rts_wdata <= 1'b1;
    lcr_brk_we <= 1'b1;
    lcr_brk_wdata <= 1'b1;
    step(1);
    mcr_rts_we <= 1'b0;
    lcr_brk_we <= 1'b0;
    rdc("rts alias", USC_ADDR_RTS_SHADOW, 32'h0000_0001);
    rdc("break alias", USC_ADDR_BRK_SHADOW, 32'h0000_0001);
    chk("sout break", 32'h0000_0000, 32'(sout));
    cfg.sir_mode <= 1'b1;
    step(2);
    n = 0;
    repeat (32) begin
      @(negedge hclk);
      n += (sir_out_n === 1'b0);
    end
    step(1);
    chk("ir pulses", 32'(2 * USC_SIR_LOW_CYC), 32'(n));
    cfg.sir_mode <= 1'b0;
    cfg.loopback <= 1'b1;
    step(2);
    chk("loop sout", 32'h0000_0001, 32'(sout));
    chk("loop sin", 32'h0000_0000, 32'(loop_sin));
    chk("loop rts_n", 32'h0000_0001, 32'(rts_n));
    chk("loop rts", 32'h0000_0001, 32'(loop_rts));
    cfg.loopback <= 1'b0;
    bus(1'b1, USC_ADDR_SOFT_RST, 32'h0000_0001);
    wait_for(ctrl_rst_n, 1'b0);
    wait_for(ctrl_rst_n, 1'b1);
    step(3);
    chk("rts after reset", 32'h0000_0000, 32'(rts_bit));
    chk("brk after reset", 32'h0000_0000, 32'(break_bit));
    tx_in <= '{1'b1, 8'h5a};
    n = 0;
    repeat (12) begin
      @(negedge hclk);
      n += (tx_in_ready === 1'b1);
    end
    step(1);
    tx_in <= '{1'b0, 8'ha5};
    chk("tx taken", 32'(USC_FIFO_DEPTH), 32'(n));
    rdc("tx full level", USC_ADDR_TX_LEVEL, 32'(USC_FIFO_DEPTH));
    chk("tx refused", 32'h0000_0000, 32'(tx_in_ready));
    drain <= 1'b1;
    step(40);
    drain <= 1'b0;
    rdc("tx drained", USC_ADDR_TX_LEVEL, 32'h0000_0000);
    tx_in <= '{1'b1, 8'h11};
    step(3);
    tx_in <= '{1'b0, 8'hee};
    chk("tx head", 32'h0000_0011, 32'(tx_out_data));
    chk("tx head valid", 32'h0000_0001, 32'(tx_out_valid));
    bus(1'b1, USC_ADDR_SOFT_RST, 32'h0000_0004);
    step(2);
    rdc("tx cleared", USC_ADDR_TX_LEVEL, 32'h0000_0000);
    chk("tx out valid", 32'h0000_0000, 32'(tx_out_valid));
    cfg <= '{afc_en: 1'b1, fifo_en: 1'b1, loopback: 1'b0, sir_mode: 1'b0, rx_trig: 2'h0};
    bus(1'b1, USC_ADDR_RTS_SHADOW, 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      cfg.rx_trig <= 2'(c);
      bus(1'b1, USC_ADDR_SOFT_RST, 32'h0000_0002);
      go <= 1'b1;
      step(60);
      go <= 1'b0;
      step(6);
      rdc("rx held level", USC_ADDR_RX_LEVEL, 32'(trg[c] + 1));
      chk("rx rts_n", 32'h0000_0001, 32'(rts_n));
      chk("rx valid", 32'h0000_0001, 32'(rx_out_valid));
    end
    bus(1'b1, USC_ADDR_SOFT_RST, 32'h0000_0002);
    step(2);
    rdc("rx cleared", USC_ADDR_RX_LEVEL, 32'h0000_0000);
    hresetn <= 1'b0;
    step(2);
    hresetn <= 1'b1;
    step(3);
    rdc("rts after hard reset", USC_ADDR_RTS_SHADOW, 32'h0000_0000);
    complete_run();
  end
  initial begin
    step(20000);
    err_total++;
    complete_run();
  end
endmodule
